// File: include/acs_pkg.sv
// Constants for the converter channel 4..7 control block.
// Assumes a 32-bit Avalon-MM slave on a single 100 MHz clock.
package acs_pkg;
  localparam int CLK_MHZ = 100;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hc;
  localparam logic [3:0] ADDR_SAMPLE = 4'h1;
  // Control register fields.
  localparam int B_REPEAT = 0;
  localparam int B_CHG_EN = 1;
  localparam int B_BATDET_EN = 2;
  localparam int B_COIN_EN = 3;
  localparam int B_HALF = 4;
  localparam int B_SEL_LO = 5;
  localparam int B_SEL_HI = 6;
  localparam int B_IDX1 = 8;
  localparam int B_IDX2 = 12;
  localparam int B_START = 16;
  // Result register fields.
  localparam int B_VAL1 = 0;
  localparam int B_VAL2 = 16;
  // Status and mask bits.
  localparam int B_IRQ_BATDET = 0;
  localparam int B_IRQ_DONE = 1;
  localparam int B_SENSE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int RUN_LEN = 8;
  localparam logic [9:0] DIE_TEMP_25C = 10'h2a8;
  // Debounce length of the battery removal sense.
  localparam int DEBOUNCE_US = 30;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  // Channel 7 routes.
  localparam logic [1:0] CH7_AIN = 2'h0;
  localparam logic [1:0] CH7_TEMP = 2'h1;
  localparam logic [1:0] CH7_USBID = 2'h2;
  localparam logic [1:0] CH7_ALT = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b100
  } acs_state_e;
endpackage : acs_pkg

// File: rtl/acs_debounce.sv
// Debounce filter for the battery removal comparator sense.
// Input is already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
module acs_debounce (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Sense
  input wire logic enable,
  input wire logic sense_in,
  output logic stable_rise
);
  logic [12:0] cnt_r;
  logic hit_r;
  wire at_end = (cnt_r == 13'(acs_pkg::DEBOUNCE_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (!rstn || !enable || !sense_in) begin
      cnt_r <= 13'h0;
      hit_r <= 1'b0;
    end else if (!hit_r) begin
      cnt_r <= at_end ? 13'h0 : cnt_r + 13'h1;
      hit_r <= at_end;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stable_rise <= 1'b0;
    end else begin
      stable_rise <= enable && sense_in && !hit_r && at_end;
    end
  end
endmodule : acs_debounce
`default_nettype wire

// File: rtl/acs_ctrl.sv
// Control for converter channels 4 to 7: input routing, scaling, result store.
// Assumes an external converter core returns signed/unsigned 10-bit codes on conv_data.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter core
  output logic conv_start,
  output logic [2:0] conv_channel,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  // Analog front end controls
  output logic chg_amp_en,
  output logic batdet_comp_en,
  output logic ch6_coin_sel,
  output logic [1:0] ch7_route,
  output logic ch7_half_scale,
  // Comparator sense from the 31/32 threshold comparator, asynchronous
  input wire logic batdet_comp_in,
  // Interrupt
  output logic irq
);
  logic [31:0] ctrl_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [2:0] idx1_r, idx2_r;
  logic [9:0] store_r [8];
  logic [2:0] slot_r;
  logic [2:0] chan_r;
  logic sync1_r, sync2_r;
  logic sense_r;
  logic ack_r;
  acs_pkg::acs_state_e state_r, state_nxt;

  wire repeat_channel_mode = ctrl_r[acs_pkg::B_REPEAT];
  wire charger_current_read_en = ctrl_r[acs_pkg::B_CHG_EN];
  wire battery_removal_detect_en = ctrl_r[acs_pkg::B_BATDET_EN];
  wire coin_cell_read_en = ctrl_r[acs_pkg::B_COIN_EN];
  wire ch7_route_sel_lo = ctrl_r[acs_pkg::B_SEL_LO];
  wire ch7_route_sel_hi = ctrl_r[acs_pkg::B_SEL_HI];
  wire [1:0] route_sel = {ch7_route_sel_hi, ch7_route_sel_lo};

  // Bus decode. A request is seen at one edge and acknowledged at the next.
  // Writes commit only at the acknowledge edge, where the master still holds
  // address and data, so nothing is applied while waitrequest is high.
  wire acc = (avs_read || avs_write) && !ack_r;
  wire wr = avs_write && ack_r;
  wire wr_ctrl = wr && (avs_address == acs_pkg::ADDR_CTRL);
  wire wr_stat = wr && (avs_address == acs_pkg::ADDR_STATUS);
  wire wr_mask = wr && (avs_address == acs_pkg::ADDR_MASK);
  wire start_req = wr_ctrl && avs_writedata[acs_pkg::B_START];
  // channel from index
  // Only channels 4 to 7 live here, so the top bit is always forced on.
  wire [2:0] start_chan = avs_writedata[acs_pkg::B_IDX1 +: 3] | 3'h4;

  // Both indexes read the flop store in the same cycle, so any two slots pair.
  wire [9:0] val1 = store_r[idx1_r];
  wire [9:0] val2 = store_r[idx2_r];
  wire [31:0] res_word = {6'h00, val2, 6'h00, val1};
  wire [31:0] stat_word = {23'h0, sense_r, 6'h0, status_r};
  wire [31:0] rd_mux =
    (avs_address == acs_pkg::ADDR_CTRL) ? {16'h0, ctrl_r[15:0]} :
    (avs_address == acs_pkg::ADDR_RESULT) ? res_word :
    (avs_address == acs_pkg::ADDR_STATUS) ? stat_word :
    (avs_address == acs_pkg::ADDR_MASK) ? {30'h0, mask_r} : 32'h0;

  // Sequencer: one conversion of the programmed channel, or eight in repeat mode.
  wire last = !repeat_channel_mode || (slot_r == 3'(acs_pkg::RUN_LEN - 1));
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acs_pkg::ST_IDLE: begin
        if (start_req) state_nxt = acs_pkg::ST_CONV;
      end
      acs_pkg::ST_CONV: begin
        if (conv_done) state_nxt = acs_pkg::ST_STORE;
      end
      acs_pkg::ST_STORE: begin
        state_nxt = last ? acs_pkg::ST_IDLE : acs_pkg::ST_CONV;
      end
      // An illegal state code falls back to idle rather than hanging the run.
      default: state_nxt = acs_pkg::ST_IDLE;
    endcase
  end

  // zero when disabled
  // Zeroing at the store means a disabled channel 4 reads zero whatever the
  // core returns, at the cost of one mux on the store path.
  wire force_zero = (chan_r == 3'h4) && !charger_current_read_en;
  wire [9:0] stored_val = force_zero ? 10'h000 : conv_data;
  // A run raises done once, on its last store.
  wire done_evt = (state_r == acs_pkg::ST_STORE) && last;

  // gated detector
  // The sense bit shows the comparator as soon as it is synchronised, while
  // the interrupt waits for the debounce below.
  wire sense_live = battery_removal_detect_en && sync2_r;
  wire deb_rise;

  // debounce counter
  // The length is fixed; any drop of the sense during the count restarts it.
  acs_debounce u_deb (
    .core_clk(core_clk),
    .rstn(rstn),
    .enable(battery_removal_detect_en),
    .sense_in(sync2_r),
    .stable_rise(deb_rise)
  );

  wire [1:0] evt = {done_evt, deb_rise};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_r <= acs_pkg::CTRL_RST;
      mask_r <= 2'h0;
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_r <= acc;
      // Read data is taken at the request edge and stands at the acknowledge.
      if (acc) avs_readdata <= rd_mux;
      if (wr_ctrl) ctrl_r <= {16'h0, avs_writedata[15:0]};
      if (wr_mask) mask_r <= avs_writedata[1:0];
    end
  end

  // read indexes
  // Indexes keep their value until software writes the control word again.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      idx1_r <= 3'h0;
      idx2_r <= 3'h0;
    end else if (wr_ctrl) begin
      idx1_r <= avs_writedata[acs_pkg::B_IDX1 +: 3];
      idx2_r <= avs_writedata[acs_pkg::B_IDX2 +: 3];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= acs_pkg::ST_IDLE;
      slot_r <= 3'h0;
      chan_r <= 3'h4;
    end else begin
      state_r <= state_nxt;
      // A start during a busy run rewinds the slot and reloads the channel; it does not cut the run.
      if (start_req) begin
        slot_r <= 3'h0;
        chan_r <= start_chan;
      end else if (state_r == acs_pkg::ST_STORE) begin
        slot_r <= slot_r + 3'h1;
      end
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_store
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        store_r[i] <= 10'h000;
      end else if (state_r == acs_pkg::ST_CONV && conv_done && slot_r == 3'(i)) begin
        store_r[i] <= stored_val;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sense_r <= 1'b0;
    end else begin
      // Two flops tame the comparator, which bears no relation to core_clk.
      sync1_r <= batdet_comp_in;
      sync2_r <= sync1_r;
      sense_r <= sense_live;
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      status_r <= (status_r & ~(wr_stat ? avs_writedata[1:0] : 2'h0)) | evt;
      // The interrupt trails status by one cycle so that it leaves a flop.
      irq <= |(status_r & mask_r);
    end
  end

  // divider choice
  // Only the two plain inputs honour the divider bit; the id pin is always
  // halved and the temperature path never is.
  wire ch7_div_route = (route_sel == acs_pkg::CH7_AIN) || (route_sel == acs_pkg::CH7_ALT);
  wire ch7_half_nxt = (route_sel == acs_pkg::CH7_USBID) ||
    (ch7_div_route && ctrl_r[acs_pkg::B_HALF]);
  // A start pulse leaves on every entry into the convert state.
  wire conv_kick = (state_nxt == acs_pkg::ST_CONV) && (state_r != acs_pkg::ST_CONV);

  // Front end routing held in flops so outputs come from registers.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      chg_amp_en <= 1'b0;
      batdet_comp_en <= 1'b0;
      ch6_coin_sel <= 1'b0;
      ch7_route <= acs_pkg::CH7_AIN;
      ch7_half_scale <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 3'h4;
      avs_waitrequest <= 1'b1;
    end else begin
      chg_amp_en <= charger_current_read_en;
      batdet_comp_en <= battery_removal_detect_en;
      ch6_coin_sel <= coin_cell_read_en;
      ch7_route <= route_sel;
      ch7_half_scale <= ch7_half_nxt;
      conv_start <= conv_kick;
      // The channel of a fresh start must leave with its first start pulse.
      conv_channel <= start_req ? start_chan : chan_r;
      avs_waitrequest <= !acc;
    end
  end
endmodule : acs_ctrl
`default_nettype wire

// File: tb/acs_ctrl_asserts.sv
// Concurrent checks on the ports of the channel 4..7 control block.
// Bound to every acs_ctrl instance; one clock domain, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_asserts (
  // Watched ports
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic chg_amp_en,
  input wire logic batdet_comp_en,
  input wire logic ch6_coin_sel,
  input wire logic [1:0] ch7_route
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic ack_w;
  logic ctl_w;
  logic [31:0] wd_r;
  logic [3:0] cnt_r;
  logic rep_r;
  assign ack_w = (avs_read | avs_write) & !avs_waitrequest;
  assign ctl_w = ack_w & avs_write & (avs_address == acs_pkg::ADDR_CTRL);
  // The start count restarts on every accepted start so a run is judged alone.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wd_r <= 32'h0;
      cnt_r <= 4'h0;
      rep_r <= 1'b0;
    end else begin
      if (ctl_w) wd_r <= avs_writedata;
      if (ctl_w && avs_writedata[acs_pkg::B_START]) begin
        rep_r <= avs_writedata[acs_pkg::B_REPEAT];
        cnt_r <= 4'h0;
      end else if (conv_start) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_start;
    ctl_w && avs_writedata[acs_pkg::B_START];
  endsequence
  chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge lasted more than one cycle");
  chk_ack_prompt: assert property (s_req |-> ##[1:2] !avs_waitrequest)
    else $error("acknowledge came late");
  chk_level_follow: assert property (ctl_w |=> ##1 {chg_amp_en, batdet_comp_en,
    ch6_coin_sel, ch7_route} == {wd_r[1], wd_r[2], wd_r[3], wd_r[6:5]})
    else $error("front end level differs from control");
  chk_start_prompt: assert property (s_start |-> ##[1:3] conv_start)
    else $error("conversion did not start");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  chk_chan_range: assert property (conv_start |-> conv_channel[2])
    else $error("channel outside four to seven");
  chk_chan_match: assert property (conv_start |-> conv_channel == (wd_r[10:8] | 3'h4))
    else $error("start pulse left with a stale channel");
  chk_run_len: assert property (rep_r && conv_start |-> cnt_r < 4'h8)
    else $error("more than eight conversions in a run");
  chk_unmapped_zero: assert property (ack_w && avs_read && avs_address == 4'h6 |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule : acs_ctrl_asserts
bind acs_ctrl acs_ctrl_asserts acs_ctrl_asserts_inst (
  .core_clk(core_clk),
  .rstn(rstn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .conv_start(conv_start),
  .conv_channel(conv_channel),
  .chg_amp_en(chg_amp_en),
  .batdet_comp_en(batdet_comp_en),
  .ch6_coin_sel(ch6_coin_sel),
  .ch7_route(ch7_route)
);
`default_nettype wire

// File: tb/acs_conv_model.sv
// Behavioural converter core answering start pulses with codes.
// Assumes one start at a time; answers alternately fast and slow.
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Converter handshake
  input wire logic conv_start,
  output logic conv_done,
  output logic [9:0] conv_data
);
  logic [2:0] k_r;
  int wait_n;
  // Data toggles outside the done cycle so a stale capture cannot pass.
  always @(posedge core_clk) begin
    if (!rstn) begin
      k_r <= 3'h0;
      wait_n <= 0;
      conv_done <= 1'b0;
      conv_data <= 10'h0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        wait_n <= k_r[0] ? 5 : 1;
      end else if (wait_n == 1) begin
        conv_done <= 1'b1;
        conv_data <= 10'h1fc + {7'h0, k_r};
        k_r <= k_r + 3'h1;
        wait_n <= 0;
      end else if (wait_n > 1) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule : acs_conv_model
`default_nettype wire

// File: tb/adc_channel4to7_select_tb.sv
// Self-checking bench for the channel 4..7 control block.
// A converter model answers starts; the bench drives the bus and the sense.
`timescale 1ns/1ps
`default_nettype none
module adc_channel4to7_select_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic batdet_comp_in = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, conv_start, conv_done, irq;
  logic chg_amp_en, batdet_comp_en, ch6_coin_sel, ch7_half_scale;
  logic [2:0] conv_channel;
  logic [9:0] conv_data;
  logic [1:0] ch7_route;
  int mismatches = 0;
  int cmp_count = 0;
  always #5 core_clk = ~core_clk;
  acs_ctrl acs_ctrl_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .conv_start(conv_start),
    .conv_channel(conv_channel),
    .conv_done(conv_done),
    .conv_data(conv_data),
    .chg_amp_en(chg_amp_en),
    .batdet_comp_en(batdet_comp_en),
    .ch6_coin_sel(ch6_coin_sel),
    .ch7_route(ch7_route),
    .ch7_half_scale(ch7_half_scale),
    .batdet_comp_in(batdet_comp_in),
    .irq(irq)
  );
  acs_conv_model acs_conv_model_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .conv_start(conv_start),
    .conv_done(conv_done),
    .conv_data(conv_data)
  );
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Request holds until waitrequest is sampled low; one idle edge follows.
  // Only the watchdog ends a wait that never sees the acknowledge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_irq
  task automatic t_regs();
    bus(1'b0, acs_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", acs_pkg::CTRL_RST, rd);
    bus(1'b1, 4'h6, 32'hffff_ffff);
    bus(1'b0, 4'h6, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("register test over");
  endtask : t_regs
  task automatic t_run(input logic en);
    logic [31:0] c;
    logic [9:0] v1, v2;
    int n;
    c = {30'h0, en, 1'b1};
    bus(1'b1, acs_pkg::ADDR_MASK, 32'h2);
    bus(1'b1, acs_pkg::ADDR_CTRL, c | 32'h1_0000);
    wait_irq(400, n);
    chk("run irq", 32'h1, {31'h0, irq});
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, acs_pkg::ADDR_CTRL, c | (k << 8) | ((k + 4) << 12));
      bus(1'b0, acs_pkg::ADDR_RESULT, 32'h0);
      v1 = en ? 10'h1fc + k[9:0] : 10'h0;
      v2 = en ? 10'h200 + k[9:0] : 10'h0;
      chk("result", {6'h0, v2, 6'h0, v1}, rd);
    end
    bus(1'b1, acs_pkg::ADDR_STATUS, 32'h2);
    tick(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("run test over");
  endtask : t_run
  // A single conversion on channel 5 with the charger path off keeps its code.
  task automatic t_single();
    int n;
    bus(1'b1, acs_pkg::ADDR_MASK, 32'h2);
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h1_0100);
    wait_irq(100, n);
    chk("single irq", 32'h1, {31'h0, irq});
    chk("channel", 32'h5, {29'h0, conv_channel});
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h1000);
    bus(1'b0, acs_pkg::ADDR_RESULT, 32'h0);
    chk("single result", {22'h0, 10'h1fc}, rd);
    bus(1'b1, acs_pkg::ADDR_STATUS, 32'h2);
    $display("single test over");
  endtask : t_single
  task automatic t_route();
    for (int s = 0; s < 16; s++) begin
      bus(1'b1, acs_pkg::ADDR_CTRL, s << 3);
      tick(1);
      chk("route", s[3:2], {30'h0, ch7_route});
      chk("coin", s[0], {31'h0, ch6_coin_sel});
      if (s[3] == s[2]) chk("half", s[1], {31'h0, ch7_half_scale});
      else chk("half fixed", s[3], {31'h0, ch7_half_scale});
    end
    $display("route test over");
  endtask : t_route
  task automatic t_batdet();
    int n;
    bus(1'b1, acs_pkg::ADDR_MASK, 32'h1);
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
    batdet_comp_in <= 1'b1;
    tick(acs_pkg::DEBOUNCE_CYC + 50);
    bus(1'b0, acs_pkg::ADDR_STATUS, 32'h0);
    chk("off event", 32'h0, {31'h0, rd[0]});
    batdet_comp_in <= 1'b0;
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h4);
    tick(1);
    chk("comp en", 32'h1, {31'h0, batdet_comp_en});
    tick(4);
    batdet_comp_in <= 1'b1;
    tick(6);
    bus(1'b0, acs_pkg::ADDR_STATUS, 32'h0);
    chk("sense", 32'h1, {31'h0, rd[8]});
    chk("early irq", 32'h0, {31'h0, irq});
    wait_irq(acs_pkg::DEBOUNCE_CYC + 100, n);
    chk("irq", 32'h1, {31'h0, irq});
    chk("debounce", 32'h1, {31'h0, n > acs_pkg::DEBOUNCE_CYC - 30});
    bus(1'b1, acs_pkg::ADDR_STATUS, 32'h1);
    tick(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    batdet_comp_in <= 1'b0;
    $display("detect test over");
  endtask : t_batdet
  task automatic complete_run();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  initial begin
    tick(20000);
    mismatches++;
    complete_run();
  end
  initial begin
    tick(16);
    rstn <= 1'b1;
    t_regs();
    t_run(1'b1);
    t_run(1'b0);
    t_single();
    t_route();
    t_batdet();
    complete_run();
  end
endmodule : adc_channel4to7_select_tb
`default_nettype wire
